/* File: plbb_defines.svh */
// constants of the byte-lane bridge: offsets, masks, codes
`ifndef PLBB_DEFINES_SVH
`define PLBB_DEFINES_SVH

// configuration-space offsets of the window base registers and the small window setting
`define PLBB_OFF_CONTROL_BASE  12'h810
`define PLBB_OFF_LARGE_BASE    12'h814
`define PLBB_OFF_MAPPING_BASE  12'h818
`define PLBB_OFF_SMALL_BASE    12'h81C
`define PLBB_OFF_SMALL_SETTING 12'h820

// writable bits of each base register, then their reset value
`define PLBB_MASK_CONTROL      32'hFFFF_FE00
`define PLBB_MASK_LARGE        32'hE000_0000
`define PLBB_MASK_MAPPING      32'hFFFE_0000
`define PLBB_MASK_SMALL        32'hFC00_0000
`define PLBB_BASE_RESET        32'h0000_0000

// local transfer size codes
`define PLBB_SIZE_LONG         2'h0
`define PLBB_SIZE_BYTE         2'h1
`define PLBB_SIZE_WORD         2'h2
`define PLBB_SIZE_TRI          2'h3

// byte-enable patterns, active low, then low-address and zero-data values
`define PLBB_BE_NONE           4'hF
`define PLBB_BE_ALL            4'h0
`define PLBB_ADDR_LOW          2'h0
`define PLBB_ADDR_HALF         2'h2
`define PLBB_DATA_ZERO         32'h0000_0000
`define PLBB_HALF_ZERO         16'h0000

`endif

/* File: plbb_pkg.sv */
// types shared by the byte-lane bridge
package plbb_pkg;

  // swap selector of one mapping entry
  typedef struct packed {
    logic       qw_swap;    // quadword swap, block transfers only
    logic [1:0] mode;       // swap modes 0..3
  } plbb_swap_t;

  // outbound request from the pci target side
  typedef struct packed {
    logic [3:0]  be_n;
    plbb_swap_t  swap;
    logic        d64;
    logic [31:0] data;
  } plbb_ob_req_t;

  // translated local bus cycle
  typedef struct packed {
    logic [1:0]  local_low_address;
    logic [1:0]  transfer_size_code;
    logic        lower_lane;
    logic        qw_swap;
    logic [31:0] data;
  } plbb_lb_cyc_t;

  // inbound request driven by the local controller
  typedef struct packed {
    logic [1:0]  local_low_address;
    logic [1:0]  transfer_size_code;
    plbb_swap_t  swap;
    logic [31:0] data;
  } plbb_ib_req_t;

  // pci master access produced from an inbound cycle
  typedef struct packed {
    logic [3:0]  be_n;
    logic [31:0] data;
  } plbb_pci_acc_t;

  // outcome of an outbound request
  typedef enum logic [1:0] {
    PLBB_TRX_OK      = 2'b00,
    PLBB_TRX_NONE    = 2'b01,
    PLBB_TRX_ABORT   = 2'b10
  } plbb_trx_t;

endpackage

/* File: plbb_bridge.sv */
// byte-lane translation and window base logic of the pci-local bridge
// Overview of operation
// - three-bit selector: two mode bits, quadword swap
// - low-half words and bytes steered to lower lanes
// - d64 packs quadwords; only full quadwords allowed
// - byte access: size 01, index xor mode
// - two-byte access: size 10, address per mode
// - three-byte access: size 11, address per mode
// - abort when swapped bytes land non-contiguous
// - no cycle for empty or split pci enables
// - mark and route lower sixteen-line cycles
// - inbound longword and tribyte give pci enables
// - inbound two-byte enables per address and mode
// - inbound byte enable at address xor mode
// - inbound bytes, aligned words from low lines
// - issue non-contiguous inbound enables as they are
// - base registers only in configuration space
// - control window 512 bytes, bits 31:9 writable
// - large window 512 MB, bits 31:29 writable
// - small window 64 MB, bits 31:26 writable
// - mapping table window spans 128 KB
// - extra register reports small window setting
`timescale 1ns/100ps
`default_nettype none
`include "plbb_defines.svh"

module plbb_bridge
(
  // clock and reset
  input  wire logic                   clk,
  input  wire logic                   rst,
  // pci configuration access
  input  wire logic                   cfg_wr,
  input  wire logic                   cfg_rd,
  input  wire logic [11:0]            cfg_addr,
  input  wire logic [3:0]             cfg_be_n,
  input  wire logic [31:0]            cfg_wdata,
  output logic                        cfg_ack,
  output logic [31:0]                 cfg_rdata,
  // pci memory decode
  input  wire logic [31:0]            mem_addr,
  output logic                        hit_control,
  output logic                        hit_large,
  output logic                        hit_mapping,
  output logic                        hit_small,
  // strap giving the small window hardware setting
  input  wire logic [5:0]             small_window_strap,
  // outbound request and translated local cycle
  input  wire logic                   ob_req,
  input  wire plbb_pkg::plbb_ob_req_t ob_in,
  output logic                        lb_start,
  output plbb_pkg::plbb_lb_cyc_t      lb_cyc,
  output logic                        pci_abort,
  output logic                        pci_no_cycle,
  // inbound local cycle and pci master access
  input  wire logic                   ib_req,
  input  wire plbb_pkg::plbb_ib_req_t ib_in,
  output logic                        pci_start,
  output plbb_pkg::plbb_pci_acc_t     pci_acc
);

  // ****************************************************************
  // translation functions
  // ****************************************************************

  // pci enables are contiguous when the asserted bytes form one run
  function automatic logic be_contig(input logic [3:0] be_n);
    logic [3:0] a;
    logic       ok;
    a  = ~be_n;
    ok = 1'b1;
    for (int i = 1; i < 3; i++)
    begin
      if (a[i - 1] && !a[i] && ((a >> (i + 1)) != 4'h0))
        ok = 1'b0;
    end
    return ok;
  endfunction

  // map one pci byte index to its local lane by xor with the mode
  function automatic logic [3:0] lane_map(input logic [3:0] act,
                                          input logic [1:0] mode);
    logic [3:0] p;
    p = '0;
    for (int i = 0; i < 4; i++)
    begin
      if (act[i])
        p[2'(i) ^ mode] = 1'b1;
    end
    return p;
  endfunction

  // lower-lane cycles: bytes at 0 or 1, or the aligned low word
  function automatic logic is_lower(input logic [1:0] a,
                                    input logic [1:0] s);
    return ((s == `PLBB_SIZE_BYTE) && (a < `PLBB_ADDR_HALF)) ||
           ((s == `PLBB_SIZE_WORD) && (a == `PLBB_ADDR_LOW));
  endfunction

  // ****************************************************************
  // outbound translation
  // ****************************************************************

  logic [3:0] ob_lanes;
  logic [1:0] ob_addr;
  logic [1:0] ob_size;
  logic       ob_lane_ok;
  logic       ob_empty;
  logic       ob_split;
  logic       ob_d64_bad;
  logic [2:0] ob_cnt;

  // lanes after swap give address and size; swap is xor of index
  always_comb
  begin
    ob_lanes = lane_map(~ob_in.be_n, ob_in.swap.mode);
    ob_addr  = `PLBB_ADDR_LOW;
    ob_cnt   = '0;
    for (int i = 3; i >= 0; i--)
    begin
      if (ob_lanes[i])
      begin
        ob_addr = 2'(i);
        ob_cnt  = ob_cnt + 3'h1;
      end
    end
    ob_size    = ob_cnt[1:0];
    ob_lane_ok = be_contig(~ob_lanes);
  end

  // empty or split pci enables give no local cycle
  assign ob_empty   = (ob_in.be_n == `PLBB_BE_NONE);
  assign ob_split   = !be_contig(ob_in.be_n);
  // quadword mode accepts only whole longwords of a full quadword
  assign ob_d64_bad = ob_in.d64 &&
                      (ob_in.be_n != `PLBB_BE_ALL);

  // one result per request; a refused request never starts a cycle
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      lb_start     <= 1'b0;
      pci_abort    <= 1'b0;
      pci_no_cycle <= 1'b0;
    end
    else
    begin
      lb_start     <= ob_req && !ob_empty && !ob_split &&
                      ob_lane_ok && !ob_d64_bad;
      pci_no_cycle <= ob_req && (ob_empty || ob_split);
      pci_abort    <= ob_req && !ob_empty && !ob_split &&
                      (!ob_lane_ok || ob_d64_bad);
    end
  end

  // outbound data: lanes swapped, upper half moved to lower lines on lower-lane cycles
  logic [31:0] ob_swapped;
  logic [31:0] ob_data;

  always_comb
  begin
    ob_swapped = `PLBB_DATA_ZERO;
    for (int i = 0; i < 4; i++)
    begin
      ob_swapped[8 * (3 - (i ^ 32'(ob_in.swap.mode))) +: 8] =
        ob_in.data[8 * i +: 8];
    end
    // big-endian byte 0 sits on the top lane; lower-lane cycles
    // move the upper half down so the local controller sees D15:0
    if (is_lower(ob_addr, ob_size))
      ob_data = {`PLBB_HALF_ZERO, ob_swapped[31:16]};
    else
      ob_data = ob_swapped;
  end

  // translated cycle held until the next accepted request
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      lb_cyc <= '0;
    else if (ob_req && !ob_empty && !ob_split &&
             ob_lane_ok && !ob_d64_bad)
    begin
      lb_cyc.local_low_address  <= ob_addr;
      lb_cyc.transfer_size_code <= ob_size;
      lb_cyc.lower_lane <= is_lower(ob_addr, ob_size);
      lb_cyc.qw_swap    <= ob_in.swap.qw_swap &&
                           ob_in.d64;
      lb_cyc.data       <= ob_data;
    end
  end

  // ****************************************************************
  // inbound translation
  // ****************************************************************

  logic [3:0]  ib_vme;
  logic [3:0]  ib_be_n;
  logic [31:0] ib_data;

  // local lanes from address and size, then unswapped to pci
  always_comb
  begin
    ib_vme = '0;
    unique case (ib_in.transfer_size_code)
      `PLBB_SIZE_LONG: ib_vme = 4'hF;
      `PLBB_SIZE_BYTE: ib_vme = 4'h1 << ib_in.local_low_address;
      `PLBB_SIZE_WORD: ib_vme = 4'(4'h3 << ib_in.local_low_address);
      `PLBB_SIZE_TRI:  ib_vme = 4'(4'h7 << ib_in.local_low_address);
    endcase
    // split enables pass as translated, never aborted
    ib_be_n = ~lane_map(ib_vme, ib_in.swap.mode);
    // byte and aligned word data arrive on the low lines; copy
    // them to both halves so any enabled lane finds them
    if (is_lower(ib_in.local_low_address, ib_in.transfer_size_code) ||
        (ib_in.transfer_size_code == `PLBB_SIZE_BYTE) ||
        ((ib_in.transfer_size_code == `PLBB_SIZE_WORD) &&
         (ib_in.local_low_address == `PLBB_ADDR_HALF)))
      ib_data = {ib_in.data[15:0], ib_in.data[15:0]};
    else
      ib_data = ib_in.data;
  end

  // pci access issued one edge after the inbound request
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      pci_start <= 1'b0;
    else
      pci_start <= ib_req;
  end

  // access fields held until the next inbound request
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      pci_acc <= '{be_n: `PLBB_BE_NONE, data: `PLBB_DATA_ZERO};
    else if (ib_req)
    begin
      pci_acc.be_n <= ib_be_n;
      pci_acc.data <= ib_data;
    end
  end

  // ****************************************************************
  // window base registers
  // ****************************************************************

  logic [31:0] control_window_base_q;
  logic [31:0] large_window_base_q;
  logic [31:0] mapping_table_base_q;
  logic [31:0] small_window_base_q;
  logic [5:0]  small_setting_q;
  logic [31:0] cfg_bytes;

  // byte enables on the configuration write pick the lanes
  always_comb
  begin
    cfg_bytes = '0;
    for (int i = 0; i < 4; i++)
      cfg_bytes[8 * i +: 8] = {8{~cfg_be_n[i]}};
  end

  // masked merge keeps read-only bits at zero
  function automatic logic [31:0] merge(input logic [31:0] old_v,
                                        input logic [31:0] wd,
                                        input logic [31:0] en,
                                        input logic [31:0] wm);
    return ((old_v & ~en) | (wd & en)) & wm;
  endfunction

  // only configuration cycles reach these, never memory space
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      control_window_base_q <= `PLBB_BASE_RESET;
      large_window_base_q   <= `PLBB_BASE_RESET;
      mapping_table_base_q  <= `PLBB_BASE_RESET;
      small_window_base_q   <= `PLBB_BASE_RESET;
    end
    else if (cfg_wr)
    begin
      if (cfg_addr == `PLBB_OFF_CONTROL_BASE)
        control_window_base_q <= merge(control_window_base_q,
          cfg_wdata, cfg_bytes, `PLBB_MASK_CONTROL);
      if (cfg_addr == `PLBB_OFF_LARGE_BASE)
        large_window_base_q <= merge(large_window_base_q,
          cfg_wdata, cfg_bytes, `PLBB_MASK_LARGE);
      if (cfg_addr == `PLBB_OFF_MAPPING_BASE)
        mapping_table_base_q <= merge(mapping_table_base_q,
          cfg_wdata, cfg_bytes, `PLBB_MASK_MAPPING);
      if (cfg_addr == `PLBB_OFF_SMALL_BASE)
        small_window_base_q <= merge(small_window_base_q,
          cfg_wdata, cfg_bytes, `PLBB_MASK_SMALL);
    end
  end

  // strap caught by the clock after reset, not by the reset itself
  logic strap_taken_q;

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      strap_taken_q <= 1'b0;
    else
      strap_taken_q <= 1'b1;
  end

  always_ff @(posedge clk)
  begin
    if (!strap_taken_q)
      small_setting_q <= small_window_strap;
  end

  // registered read data; unmapped offsets read zero
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      cfg_ack   <= 1'b0;
      cfg_rdata <= `PLBB_DATA_ZERO;
    end
    else
    begin
      cfg_ack <= cfg_wr || cfg_rd;
      if (cfg_rd)
      begin
        unique case (cfg_addr)
          `PLBB_OFF_CONTROL_BASE:  cfg_rdata <= control_window_base_q;
          `PLBB_OFF_LARGE_BASE:    cfg_rdata <= large_window_base_q;
          `PLBB_OFF_MAPPING_BASE:  cfg_rdata <= mapping_table_base_q;
          `PLBB_OFF_SMALL_BASE:    cfg_rdata <= small_window_base_q;
          `PLBB_OFF_SMALL_SETTING:
            cfg_rdata <= {small_setting_q, 26'h0};
          default:                 cfg_rdata <= `PLBB_DATA_ZERO;
        endcase
      end
    end
  end

  // ****************************************************************
  // memory window decode
  // ****************************************************************

  // natural alignment: compare only the writable base bits; the
  // host keeps windows apart, so several hits are its fault
  assign hit_control = ((mem_addr & `PLBB_MASK_CONTROL) ==
                        control_window_base_q);
  assign hit_large   = ((mem_addr & `PLBB_MASK_LARGE) ==
                        large_window_base_q);
  assign hit_mapping = ((mem_addr & `PLBB_MASK_MAPPING) ==
                        mapping_table_base_q);
  assign hit_small   = ((mem_addr & `PLBB_MASK_SMALL) ==
                        small_window_base_q);

endmodule
`default_nettype wire

/* File: plbb_bridge_properties.sv */
// concurrent port checks of the byte-lane bridge
`timescale 1ns/100ps
`default_nettype none
module plbb_bridge_properties
(
  // clock and reset
  input wire logic                    clk,
  input wire logic                    rst,
  // configuration handshake
  input wire logic                    cfg_wr,
  input wire logic                    cfg_rd,
  input wire logic                    cfg_ack,
  // outbound side
  input wire logic                    ob_req,
  input wire plbb_pkg::plbb_ob_req_t  ob_in,
  input wire logic                    lb_start,
  input wire plbb_pkg::plbb_lb_cyc_t  lb_cyc,
  input wire logic                    pci_abort,
  input wire logic                    pci_no_cycle,
  // inbound side
  input wire logic                    ib_req,
  input wire plbb_pkg::plbb_ib_req_t  ib_in,
  input wire logic                    pci_start,
  input wire plbb_pkg::plbb_pci_acc_t pci_acc
);
  // ****************
  // checks
  // ****************
  default clocking @(posedge clk); endclocking
  default disable iff (rst);

  // lowest enabled pci byte of an active-low enable set
  function automatic logic [1:0] low_idx(input logic [3:0] b);
    low_idx = !b[0] ? 2'h0 : !b[1] ? 2'h1 : !b[2] ? 2'h2 : 2'h3;
  endfunction

  // request and answer steps of an outbound transfer
  sequence s_one_byte;
    ob_req && !ob_in.d64 && $countones(~ob_in.be_n) == 1;
  endsequence
  sequence s_started;
    lb_start && !pci_abort && !pci_no_cycle;
  endsequence

  a_cfg_answer: assert property ((cfg_wr || cfg_rd) |=> cfg_ack)
    else $error("config access not acknowledged next cycle");
  a_ob_onehot: assert property (ob_req |=>
    $onehot({lb_start, pci_abort, pci_no_cycle}))
    else $error("outbound answer not exactly one pulse");
  a_empty_none: assert property (ob_req && ob_in.be_n == 4'hF |=>
    pci_no_cycle) else $error("empty enables started a cycle");
  a_byte_code: assert property (s_one_byte |=> s_started and
    (lb_cyc.transfer_size_code == 2'h1 && lb_cyc.local_low_address ==
    (low_idx($past(ob_in.be_n)) ^ $past(ob_in.swap.mode))))
    else $error("single byte code wrong");
  a_long_code: assert property (ob_req && ob_in.be_n == 4'h0 |=>
    s_started and (lb_cyc.local_low_address == 2'h0 &&
    lb_cyc.transfer_size_code == 2'h0)) else $error("longword code wrong");
  // empty or split enables answer no-cycle first, so leave them out
  a_d64_abort: assert property (ob_req && ob_in.d64 &&
    ob_in.be_n != 4'h0 && ob_in.be_n != 4'hF &&
    !(ob_in.be_n inside {4'h2, 4'h4, 4'h5, 4'h6, 4'hA}) |=> pci_abort)
    else $error("partial d64 not aborted");
  a_qw_flag: assert property (ob_req && ob_in.be_n == 4'h0 |=>
    lb_cyc.qw_swap == ($past(ob_in.swap.qw_swap) & $past(ob_in.d64)))
    else $error("quadword swap flag wrong");
  a_lb_hold: assert property (!ob_req |=> $stable(lb_cyc))
    else $error("local cycle changed without request");
  a_ib_answer: assert property (ib_req |=> pci_start)
    else $error("inbound access not issued");
  a_ib_long: assert property (ib_req &&
    ib_in.transfer_size_code == 2'h0 |=> pci_acc.be_n == 4'h0)
    else $error("inbound longword enables wrong");
endmodule

bind plbb_bridge plbb_bridge_properties chk_u (
  .clk(clk), .rst(rst), .cfg_wr(cfg_wr), .cfg_rd(cfg_rd),
  .cfg_ack(cfg_ack), .ob_req(ob_req), .ob_in(ob_in),
  .lb_start(lb_start), .lb_cyc(lb_cyc), .pci_abort(pci_abort),
  .pci_no_cycle(pci_no_cycle), .ib_req(ib_req), .ib_in(ib_in),
  .pci_start(pci_start), .pci_acc(pci_acc)
);
`default_nettype wire

/* File: plbb_host_model.sv */
// configuring pci host: config space accesses
`timescale 1ns/100ps
`default_nettype none
module plbb_host_model
(
  // clock
  input  wire logic        clk,
  // configuration access
  output logic             cfg_wr,
  output logic             cfg_rd,
  output logic [11:0]      cfg_addr,
  output logic [3:0]       cfg_be_n,
  output logic [31:0]      cfg_wdata,
  // answer
  input  wire logic        cfg_ack,
  input  wire logic [31:0] cfg_rdata
);
  // idle bus at time zero
  initial
  begin
    cfg_wr = 1'h0;
    cfg_rd = 1'h0;
    cfg_addr = 12'h000;
    cfg_be_n = 4'hF;
    cfg_wdata = 32'h0000_0000;
  end

  // one strobe pulse; released address and data lines show the inverse, not stale data
  task automatic access(input logic w, input logic [11:0] a,
    input logic [3:0] b, input logic [31:0] d,
    output logic ack, output logic [31:0] rd);
    @(posedge clk);
    cfg_wr <= w;
    cfg_rd <= !w;
    cfg_addr <= a;
    cfg_be_n <= b;
    cfg_wdata <= d;
    @(posedge clk);
    cfg_wr <= 1'h0;
    cfg_rd <= 1'h0;
    cfg_addr <= ~a;
    cfg_wdata <= ~d;
    @(negedge clk);
    ack = cfg_ack;
    rd = cfg_rdata;
  endtask
endmodule
`default_nettype wire

/* File: pci_local_byte_lane_bridge_test.sv */
// self-checking bench of the byte-lane bridge
`timescale 1ns/100ps
`default_nettype none
module pci_local_byte_lane_bridge_test;
  // ****************
  // signals
  // ****************
  typedef struct packed {
    logic       ib;
    logic [1:0] oc;
    logic       ll;
    logic [3:0] a;
    logic [3:0] m;
    logic [3:0] x;
  } plbb_row_t;
  logic                    clk = 1'h0;
  logic                    rst = 1'h1;
  logic                    cfg_wr, cfg_rd, cfg_ack, ack;
  logic                    hc, hl, hm, hs, lb_start, pci_abort;
  logic                    pci_no_cycle, pci_start;
  logic                    ob_req = 1'h0;
  logic                    ib_req = 1'h0;
  logic [11:0]             cfg_addr;
  logic [3:0]              cfg_be_n;
  logic [31:0]             cfg_wdata, cfg_rdata, rd;
  logic [31:0]             mem_addr = 32'h0000_0000;
  plbb_pkg::plbb_ob_req_t  ob_in = '0;
  plbb_pkg::plbb_ib_req_t  ib_in = '0;
  plbb_pkg::plbb_lb_cyc_t  lb_cyc;
  plbb_pkg::plbb_pci_acc_t pci_acc;
  plbb_row_t               rw;
  int                      err_total = 0;
  int                      n_checks = 0;
  // outbound rows, then inbound rows
  logic [15:0] tbl [0:27] = '{
    16'h1E01, 16'h1E15, 16'h0E29, 16'h0E3D, 16'h1725, 16'h1C02, 16'h0C2A,
    16'h0906, 16'h4910, 16'h1332, 16'h0803, 16'h0837, 16'h4110, 16'h0020,
    16'h2F00, 16'h2510, 16'h2610, 16'h8010, 16'h8308, 16'h8331, 16'h8712,
    16'h8223, 16'h8616, 16'h8A03, 16'h812B, 16'h8D3E, 16'h851E, 16'h8917};
  logic [11:0] offs [0:3] = '{12'h810, 12'h814, 12'h818, 12'h81C};
  logic [31:0] msk [0:3] = '{32'hFFFF_FE00, 32'hE000_0000, 32'hFFFE_0000,
    32'hFC00_0000};
  logic [31:0] bas [0:3] = '{32'h0000_0200, 32'hE000_0000, 32'h0002_0000,
    32'h0400_0000};
  logic [31:0] ha [0:5] = '{32'h0000_03FC, 32'h0000_0400, 32'h0003_FFFC,
    32'h07FF_FFFC, 32'h0800_0000, 32'hE000_0000};
  logic [3:0] he [0:5] = '{4'h8, 4'h0, 4'h2, 4'h1, 4'h0, 4'h4};

  always #12.5 clk = ~clk;

  plbb_host_model host_u (.clk(clk), .cfg_wr(cfg_wr), .cfg_rd(cfg_rd),
    .cfg_addr(cfg_addr), .cfg_be_n(cfg_be_n), .cfg_wdata(cfg_wdata),
    .cfg_ack(cfg_ack), .cfg_rdata(cfg_rdata));
  plbb_bridge dut_u (.clk(clk), .rst(rst), .cfg_wr(cfg_wr),
    .cfg_rd(cfg_rd), .cfg_addr(cfg_addr), .cfg_be_n(cfg_be_n),
    .cfg_wdata(cfg_wdata), .cfg_ack(cfg_ack), .cfg_rdata(cfg_rdata),
    .mem_addr(mem_addr), .hit_control(hc), .hit_large(hl),
    .hit_mapping(hm), .hit_small(hs), .small_window_strap(6'h2A),
    .ob_req(ob_req), .ob_in(ob_in), .lb_start(lb_start), .lb_cyc(lb_cyc),
    .pci_abort(pci_abort), .pci_no_cycle(pci_no_cycle), .ib_req(ib_req),
    .ib_in(ib_in), .pci_start(pci_start), .pci_acc(pci_acc));

  // ****************
  // tasks
  // ****************
  task automatic chk(input logic [39:0] s, input logic [39:0] e,
    input string n);
    n_checks++;
    if (s !== e)
    begin
      err_total++;
      $display("ERROR %s expected %h seen %h", n, e, s);
    end
  endtask

  task automatic cfg(input logic w, input logic [11:0] a,
    input logic [3:0] b, input logic [31:0] d);
    host_u.access(w, a, b, d, ack, rd);
    chk(ack, 32'h1, "cfg_ack");
  endtask

  // one request pulse, then look between the answer's edges
  task automatic go(input logic ob, input logic [39:0] v);
    @(posedge clk);
    if (ob)
    begin
      ob_req <= 1'h1;
      ob_in <= v;
    end
    else
    begin
      ib_req <= 1'h1;
      ib_in <= v[38:0];
    end
    @(posedge clk);
    ob_req <= 1'h0;
    ib_req <= 1'h0;
    @(negedge clk);
  endtask

  task final_report;
    $display("checks %0d errors %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  // watchdog well beyond the expected run
  initial
  begin
    repeat (4000) @(posedge clk);
    err_total++;
    final_report;
  end

  // ****************
  // sequence
  // ****************
  initial
  begin
    repeat (20) @(posedge clk);
    rst <= 1'h0;
    @(negedge clk);
    chk(pci_acc.be_n, 4'hF, "reset be_n");
    chk(lb_cyc, 32'h0, "reset lb_cyc");
    for (int i = 0; i < 28; i++)
    begin
      rw = tbl[i];
      if (rw.ib)
      begin
        go(1'h0, {1'h0, rw.a, 1'h0, rw.m[1:0], 32'hAABB_CCDD});
        chk(pci_start, 32'h1, "pci_start");
        chk(pci_acc.be_n, rw.x, "pci_be_n");
      end
      else
      begin
        go(1'h1, {rw.a, 1'h0, rw.m[1:0], 1'h0, 32'h4433_2211});
        chk({pci_abort, pci_no_cycle, lb_start},
          {rw.oc, rw.oc == 2'h0}, "outcome");
        if (rw.oc == 2'h0)
          chk(lb_cyc[37:33], {rw.x, rw.ll}, "lb_code");
      end
    end
    // lower-lane data and quadword handling
    go(1'h1, {4'hE, 1'h0, 2'h1, 1'h0, 32'h4433_2211});
    chk(lb_cyc.data, 32'h0000_2211, "lower data");
    go(1'h1, {4'h0, 1'h1, 2'h0, 1'h1, 32'h4433_2211});
    chk(lb_cyc.qw_swap, 32'h1, "qw_swap");
    go(1'h1, {4'hE, 1'h1, 2'h0, 1'h1, 32'h4433_2211});
    chk({pci_abort, lb_start, lb_cyc.qw_swap}, 3'h5, "d64 part");
    go(1'h0, {1'h0, 2'h0, 2'h1, 1'h0, 2'h0, 32'hAABB_CCDD});
    chk(pci_acc.data, 32'hCCDD_CCDD, "ib data");
    // base registers: reset value, writable bits, byte enables
    for (int i = 0; i < 4; i++)
    begin
      cfg(1'h0, offs[i], 4'h0, 32'h0);
      chk(rd, 32'h0, "base reset");
      cfg(1'h1, offs[i], 4'h0, 32'hFFFF_FFFF);
      cfg(1'h0, offs[i], 4'h0, 32'h0);
      chk(rd, msk[i], "base mask");
    end
    cfg(1'h1, 12'h810, 4'h7, 32'h0);
    cfg(1'h0, 12'h810, 4'h0, 32'h0);
    chk(rd, 32'h00FF_FE00, "byte write");
    cfg(1'h1, 12'h820, 4'h0, 32'h0);
    cfg(1'h0, 12'h820, 4'h0, 32'h0);
    chk(rd, 32'hA800_0000, "setting");
    cfg(1'h0, 12'h900, 4'h0, 32'h0);
    chk(rd, 32'h0, "unmapped");
    // disjoint windows, bases before any use
    for (int i = 0; i < 4; i++)
      cfg(1'h1, offs[i], 4'h0, bas[i]);
    for (int i = 0; i < 6; i++)
    begin
      @(posedge clk);
      mem_addr <= ha[i];
      @(negedge clk);
      chk({hc, hl, hm, hs}, he[i], "hits");
    end
    // second reset in mid-run
    @(posedge clk);
    rst <= 1'h1;
    repeat (2) @(posedge clk);
    rst <= 1'h0;
    cfg(1'h0, 12'h814, 4'h0, 32'h0);
    chk(rd, 32'h0, "base rereset");
    chk(pci_acc.be_n, 4'hF, "be_n rereset");
    final_report;
  end
endmodule
`default_nettype wire
